// ==== src/csds_pkg.sv ====
// Package with constants and types for the crystal start-up delay selector.
package csds_pkg;

  // Band codes on the upper three clock-select fuse bits.
  localparam logic [2:0] BAND_FULL_SWING = 3'h3;
  localparam logic [2:0] BAND_LP_0 = 3'h4;
  localparam logic [2:0] BAND_LP_1 = 3'h5;
  localparam logic [2:0] BAND_LP_2 = 3'h6;
  localparam logic [2:0] BAND_LP_3 = 3'h7;

  // Oscillator cycle counts, K meaning 1024.
  localparam int unsigned K_CYCLES = 1024;
  localparam logic [14:0] WAKE_258 = 15'd258;
  localparam logic [14:0] WAKE_1K = 15'(1 * K_CYCLES);
  localparam logic [14:0] WAKE_16K = 15'(16 * K_CYCLES);
  localparam logic [14:0] RESET_FIXED = 15'd14;

  // Watchdog oscillator time-out counts.
  localparam logic [13:0] TOUT_NONE = 14'd0;
  localparam logic [13:0] TOUT_4MS = 14'd512;
  localparam logic [13:0] TOUT_65MS = 14'd8192;

  // AXI4-Lite register byte offsets.
  localparam logic [3:0] REG_CONFIG = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_COUNTS = 4'h8;

  // Reset value of the software fuse register: full swing, 16K, 65 ms.
  localparam logic [6:0] FUSE_RESET = 7'h37;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Oscillator modes.
  typedef enum logic [2:0] {
    MODE_NONE = 3'h0,
    MODE_LP_04_09 = 3'h1,
    MODE_LP_09_30 = 3'h2,
    MODE_LP_30_80 = 3'h3,
    MODE_LP_80_160 = 3'h4,
    MODE_FULL_SWING = 3'h5
  } csds_mode_e;

  // Start-up sequencer states, Gray coded along the path.
  typedef enum logic [1:0] {
    ST_HOLD = 2'b00,
    ST_TIMEOUT = 2'b01,
    ST_STARTUP = 2'b11,
    ST_RUN = 2'b10
  } csds_state_e;

endpackage : csds_pkg

// ==== src/csds_cnt_if.sv ====
// Interface that carries a count request and its completion.
`timescale 1ns/1ps
interface csds_cnt_if;
  logic start;
  logic [14:0] limit;
  logic done;
  modport master (output start, output limit, input done);
  modport counter (input start, input limit, output done);
endinterface : csds_cnt_if

// ==== src/csds_counter.sv ====
// Start-up counter clocked by the system clock, counting oscillator cycle ticks.
`timescale 1ns/1ps
module csds_counter (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Tick of the counted oscillator.
  input wire logic tick,
  // Request and completion.
  csds_cnt_if.counter cnt
);
  import csds_pkg::*;

  typedef struct packed {
    logic busy;
    logic [14:0] count;
    logic done;
  } csds_cnt_s;

  csds_cnt_s st;
  csds_cnt_s next_st;

  // Loads on start, counts ticks and pulses done at the limit.
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    if (cnt.start) begin
      next_st.busy = (cnt.limit != 15'h0);
      next_st.count = 15'h0;
      next_st.done = (cnt.limit == 15'h0);
    end else if (st.busy && tick) begin
      next_st.count = st.count + 15'h1;
      if (st.count + 15'h1 >= cnt.limit) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cnt.done = st.done;

endmodule // csds_counter

// ==== src/csds_top.sv ====
// Crystal start-up delay selector with an AXI4-Lite register slave.
// Notes on behaviour
// - Low-power bands: codes 100,101,110,111 select 0.4-0.9, 0.9-3, 3-8, 8-16 MHz.
// - Upper select code 011 picks the full-swing 0.4-20 MHz mode.
// - Start-up delay comes from lowest select bit plus two-bit start-up field.
// - Bit 0, field 00/01: 258 cycles wake; reset adds 14 plus 4.1/65 ms.
// - Bit 0, field 10: 1K wake; reset adds only 14 cycles.
// - Bit0/11 and bit1/00: 1K wake; reset adds 14 plus 4.1/65 ms.
// - Bit 1, field 01: 16K wake; reset adds only 14 cycles.
// - Bit 1, field 10/11: 16K wake; reset adds 14 plus 4.1/65 ms.
// - Full-swing mode uses the same eight-entry delay mapping.
// - Divide-by-eight fuse divides the crystal-derived clock by eight.
// - Wake-up from power-down or power-save skips the reset time-out.
// - Time-out counted on watchdog oscillator: 512 or 8192 cycles.
// - Counter on oscillator output holds internal reset until count elapses.
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module csds_top (
  // System clock and reset.
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Oscillator and watchdog oscillator as sampled levels.
  input wire logic OSC_CLK_IN,
  input wire logic WDT_OSC_IN,
  // Wake-up request from power-down or power-save.
  input wire logic WAKE_REQ,
  // Start-up outputs.
  output logic INTERNAL_RESET,
  output logic DIV_CLK_OUT,
  output logic [2:0] OSC_MODE,
  // AXI4-Lite write address channel.
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  // AXI4-Lite write data channel.
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response channel.
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read address channel.
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  // AXI4-Lite read data channel.
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  import csds_pkg::*;

  typedef struct packed {
    logic [1:0] osc_sync;
    logic [1:0] wdt_sync;
    logic [1:0] wake_sync;
    logic osc_last;
    logic wdt_last;
    logic wake_last;
    logic [6:0] fuses;
    logic div8;
    csds_state_e state;
    logic start;
    logic [14:0] limit;
    logic int_reset;
    logic [2:0] div_cnt;
    logic div_clk;
    logic [2:0] mode;
    logic aw_held;
    logic [3:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic aw_rdy;
    logic w_rdy;
    logic ar_rdy;
  } csds_s;

  csds_s st;
  csds_s next_st;
  logic cnt_tick;
  csds_cnt_if cnt ();

  // Fields of the fuse register, bits [3:0] select and [5:4] start-up field.
  logic [2:0] oscillator_band_select;
  logic startup_group_select_bit;
  logic [1:0] startup_time_field;
  logic [14:0] wake_cycles;
  logic [13:0] tout_cycles;
  logic osc_rise;
  logic wdt_rise;
  logic wake_rise;

  assign oscillator_band_select = st.fuses[3:1];
  assign startup_group_select_bit = st.fuses[0];
  assign startup_time_field = st.fuses[5:4];
  assign osc_rise = st.osc_sync[1] & ~st.osc_last;
  assign wdt_rise = st.wdt_sync[1] & ~st.wdt_last;
  assign wake_rise = st.wake_sync[1] & ~st.wake_last;

  // Eight-entry delay table shared by both crystal kinds.
  always_comb begin
    wake_cycles = WAKE_16K;
    tout_cycles = TOUT_65MS;
    case ({startup_group_select_bit, startup_time_field})
      3'h0: begin
        wake_cycles = WAKE_258;
        tout_cycles = TOUT_4MS;
      end
      3'h1: begin
        wake_cycles = WAKE_258;
        tout_cycles = TOUT_65MS;
      end
      3'h2: begin
        wake_cycles = WAKE_1K;
        tout_cycles = TOUT_NONE;
      end
      3'h3: begin
        wake_cycles = WAKE_1K;
        tout_cycles = TOUT_4MS;
      end
      3'h4: begin
        wake_cycles = WAKE_1K;
        tout_cycles = TOUT_65MS;
      end
      3'h5: begin
        wake_cycles = WAKE_16K;
        tout_cycles = TOUT_NONE;
      end
      3'h6: begin
        wake_cycles = WAKE_16K;
        tout_cycles = TOUT_4MS;
      end
      3'h7: begin
        wake_cycles = WAKE_16K;
        tout_cycles = TOUT_65MS;
      end
      default: begin
        wake_cycles = WAKE_16K;
        tout_cycles = TOUT_65MS;
      end
    endcase
  end

  // The counter ticks on watchdog edges during the time-out, else on oscillator edges.
  assign cnt_tick = (st.state == ST_TIMEOUT) ? wdt_rise : osc_rise;
  assign cnt.start = st.start;
  assign cnt.limit = st.limit;

  csds_counter u_counter (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .tick(cnt_tick),
    .cnt(cnt)
  );

  // Next-state logic for synchronisers, sequencer, divider and register slave.
  always_comb begin
    next_st = st;
    next_st.osc_sync = {st.osc_sync[0], OSC_CLK_IN};
    next_st.wdt_sync = {st.wdt_sync[0], WDT_OSC_IN};
    next_st.wake_sync = {st.wake_sync[0], WAKE_REQ};
    next_st.osc_last = st.osc_sync[1];
    next_st.wdt_last = st.wdt_sync[1];
    next_st.wake_last = st.wake_sync[1];
    next_st.start = 1'b0;

    // Oscillator mode decode from the band code.
    case (oscillator_band_select)
      BAND_FULL_SWING: next_st.mode = MODE_FULL_SWING;
      BAND_LP_0: next_st.mode = MODE_LP_04_09;
      BAND_LP_1: next_st.mode = MODE_LP_09_30;
      BAND_LP_2: next_st.mode = MODE_LP_30_80;
      BAND_LP_3: next_st.mode = MODE_LP_80_160;
      default: next_st.mode = MODE_NONE;
    endcase

    // Start-up sequencer: reset path adds 14 cycles and the time-out.
    case (st.state)
      ST_HOLD: begin
        next_st.int_reset = 1'b1;
        next_st.state = ST_TIMEOUT;
        next_st.start = 1'b1;
        next_st.limit = {1'b0, tout_cycles};
      end
      ST_TIMEOUT: begin
        if (cnt.done) begin
          next_st.state = ST_STARTUP;
          next_st.start = 1'b1;
          next_st.limit = RESET_FIXED;
        end
      end
      ST_STARTUP: begin
        if (cnt.done) begin
          next_st.state = ST_RUN;
          next_st.int_reset = 1'b0;
        end
      end
      ST_RUN: begin
        if (wake_rise) begin
          next_st.state = ST_STARTUP;
          next_st.int_reset = 1'b1;
          next_st.start = 1'b1;
          next_st.limit = wake_cycles;
        end
      end
      default: next_st.state = ST_HOLD;
    endcase

    // Divider on oscillator edges, by eight when the fuse says so.
    if (osc_rise) begin
      if (!st.div8) begin
        next_st.div_clk = ~st.div_clk;
      end else begin
        next_st.div_cnt = st.div_cnt + 3'h1;
        if (st.div_cnt == 3'h3 || st.div_cnt == 3'h7) begin
          next_st.div_clk = ~st.div_clk;
        end
      end
    end

    // Write address and data are taken in either order.
    if (S_AXI_AWVALID && !st.aw_held) begin
      next_st.aw_held = 1'b1;
      next_st.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !st.w_held) begin
      next_st.w_held = 1'b1;
      next_st.w_data = S_AXI_WDATA;
      next_st.w_strb = S_AXI_WSTRB;
    end
    if (st.aw_held && st.w_held && !st.bvalid) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = RESP_OKAY;
      if (st.aw_addr == REG_CONFIG) begin
        if (st.w_strb[0]) begin
          next_st.fuses = st.w_data[6:0];
          next_st.div8 = st.w_data[7];
        end
      end else if (st.aw_addr != REG_STATUS && st.aw_addr != REG_COUNTS) begin
        next_st.bresp = RESP_SLVERR;
      end
    end
    if (st.bvalid && S_AXI_BREADY) begin
      next_st.bvalid = 1'b0;
    end

    // Read channel.
    if (S_AXI_ARVALID && !st.rvalid) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = RESP_OKAY;
      case (S_AXI_ARADDR)
        REG_CONFIG: next_st.rdata = {24'h0, st.div8, st.fuses};
        REG_STATUS: next_st.rdata = {26'h0, st.mode, st.state, st.int_reset};
        REG_COUNTS: next_st.rdata = {3'h0, tout_cycles, wake_cycles};
        default: begin
          next_st.rdata = 32'h0;
          next_st.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st.rvalid && S_AXI_RREADY) begin
      next_st.rvalid = 1'b0;
    end

    // Ready flags are registered copies of the channel occupancy, so the ports come straight from flops.
    next_st.aw_rdy = !next_st.aw_held;
    next_st.w_rdy = !next_st.w_held;
    next_st.ar_rdy = !next_st.rvalid;
  end

  // State register.
  always_ff @(posedge SYS_CLK) begin
    if (!RSTN) begin
      st <= '0;
      st.fuses <= FUSE_RESET;
      st.int_reset <= 1'b1;
      st.state <= ST_HOLD;
      st.aw_rdy <= 1'b1;
      st.w_rdy <= 1'b1;
      st.ar_rdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign INTERNAL_RESET = st.int_reset;
  assign DIV_CLK_OUT = st.div_clk;
  assign OSC_MODE = st.mode;
  assign S_AXI_AWREADY = st.aw_rdy;
  assign S_AXI_WREADY = st.w_rdy;
  assign S_AXI_BVALID = st.bvalid;
  assign S_AXI_BRESP = st.bresp;
  assign S_AXI_ARREADY = st.ar_rdy;
  assign S_AXI_RVALID = st.rvalid;
  assign S_AXI_RDATA = st.rdata;
  assign S_AXI_RRESP = st.rresp;

endmodule // csds_top

// ==== dv/csds_xtal_model.sv ====
// Free-running resonator and watchdog oscillator model for the start-up selector.
`timescale 1ns/1ps
module csds_xtal_model (
  // Reference clock.
  input wire logic clk,
  // Oscillator levels.
  output logic osc,
  output logic wdt
);
  // A ceramic resonator, so every start-up setting the bench programs is a legal one.
  initial begin
    osc = 1'b0;
    wdt = 1'b0;
  end

  // Both oscillators run free and toggle on every clock, giving one rise per two cycles.
  always @(posedge clk) begin
    osc <= ~osc;
    wdt <= ~wdt;
  end
endmodule // csds_xtal_model

// ==== dv/csds_top_chk.sv ====
// Port checker for the crystal start-up delay selector.
`timescale 1ns/1ps
module csds_top_chk import csds_pkg::*; (
  // Clock and reset.
  input wire logic SYS_CLK,
  input wire logic RSTN,
  // Start-up signals.
  input wire logic WAKE_REQ,
  input wire logic INTERNAL_RESET,
  input wire logic [2:0] OSC_MODE,
  // Register bus signals.
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0] S_AXI_RRESP,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  // Reset leaves the internal reset high and both answers idle.
  AST_RST_HOLD: assert property ($rose(RSTN) |-> INTERNAL_RESET && !S_AXI_BVALID && !S_AXI_RVALID)
    else $error("internal reset or answer wrong at reset release");
  AST_MODE_RST: assert property ($rose(RSTN) |-> ##1 OSC_MODE == MODE_FULL_SWING)
    else $error("mode after reset is not full swing");
  AST_WAKE_RST: assert property ($rose(WAKE_REQ) && !INTERNAL_RESET |-> ##[1:6] INTERNAL_RESET)
    else $error("wake-up did not raise the internal reset");
  // Register bus handshakes.
  AST_B_ANS: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write response missing");
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  AST_R_ANS: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer missing");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer dropped early");
  AST_AR_BLOCK: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read address accepted while answer pending");
  AST_RD_ERR: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 4'hc
    |=> S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0)
    else $error("unmapped read not refused");

  // Main scenarios.
  COV_WAKE: cover property ($rose(WAKE_REQ) && !INTERNAL_RESET);
  COV_B_STALL: cover property (S_AXI_BVALID && !S_AXI_BREADY);
  COV_RD_ERR: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);
endmodule // csds_top_chk

bind csds_top csds_top_chk u_csds_top_chk (.SYS_CLK(SYS_CLK), .RSTN(RSTN), .WAKE_REQ(WAKE_REQ),
  .INTERNAL_RESET(INTERNAL_RESET), .OSC_MODE(OSC_MODE), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY));

// ==== dv/tb.sv ====
// Self-checking testbench for the crystal start-up delay selector.
`timescale 1ns/1ps
module tb;
  import csds_pkg::*;
  logic clk, rstn, wake, awv, wv, bready, arv, rready, dprev;
  logic [3:0] awaddr, araddr, strb;
  logic [31:0] wdata, d;
  logic [1:0] r;
  logic osc, wdt, irst, div_out, aw_rdy, w_rdy, b_vld, ar_rdy, r_vld;
  logic [2:0] mode;
  logic [1:0] b_resp, r_resp;
  logic [31:0] r_data;
  int num_errors, num_checks, cyc, n, t;
  // Config, wake cycles, time-out cycles and mode for each fuse setting.
  logic [31:0] tab [8][4] = '{'{8, 258, 512, 1}, '{26, 258, 8192, 2}, '{44, 1024, 0, 3},
    '{62, 1024, 512, 4}, '{7, 1024, 8192, 5}, '{23, 16384, 0, 5}, '{39, 16384, 512, 5}, '{134, 258, 512, 5}};

  csds_xtal_model u_csds_xtal_model (.clk(clk), .osc(osc), .wdt(wdt));
  csds_top u_csds_top (.SYS_CLK(clk), .RSTN(rstn), .OSC_CLK_IN(osc), .WDT_OSC_IN(wdt), .WAKE_REQ(wake),
    .INTERNAL_RESET(irst), .DIV_CLK_OUT(div_out), .OSC_MODE(mode), .S_AXI_AWADDR(awaddr),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(aw_rdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(strb),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(w_rdy), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_vld),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(ar_rdy),
    .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_vld), .S_AXI_RREADY(rready));

  // Clock of 10 ns.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 99000) begin
      num_errors++;
      finish_test();
    end
  end

  // Compares a value within a tolerance.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    logic ok;
    ok = (got + tol >= exp) && (got <= exp + tol);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register write; the response is accepted late to exercise the hold.
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      if (aw_rdy === 1'b1) awv <= 1'b0;
      if (w_rdy === 1'b1) wv <= 1'b0;
      if (k++ == 2) bready <= 1'b1;
    end while (!(b_vld === 1'b1 && bready === 1'b1));
    rs = b_resp;
    bready <= 1'b0;
  endtask

  // Register read; the answer is accepted late to exercise the hold.
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    int k;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      if (ar_rdy === 1'b1) arv <= 1'b0;
      if (k++ == 2) rready <= 1'b1;
    end while (!(r_vld === 1'b1 && rready === 1'b1));
    v = r_data;
    rs = r_resp;
    rready <= 1'b0;
  endtask

  // Counts cycles from now until the internal reset has risen and fallen.
  task automatic seq_len(output int m);
    m = 0;
    while (irst !== 1'b1 && m < 20) begin @(posedge clk); m++; end
    while (irst !== 1'b0) begin @(posedge clk); m++; end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Main sequence.
  initial begin
    rstn = 1'b0; wake = 1'b0; awv = 1'b0; wv = 1'b0; bready = 1'b0; arv = 1'b0; rready = 1'b0;
    awaddr = 4'h0; araddr = 4'h0; wdata = 32'h0; strb = 4'hf; num_errors = 0; num_checks = 0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    seq_len(n);
    chk(n, 2 * (8192 + 14), 12);
    chk(mode, 5, 0);
    rd(4'h8, d, r);
    chk(d, 32'h10004000, 0);
    rd(4'h4, d, r);
    chk(d, 32'h2c, 0);
    for (int i = 0; i < 8; i++) begin
      wr(4'h0, tab[i][0], r);
      chk(r, RESP_OKAY, 0);
      @(posedge clk);
      wake <= 1'b1;
      repeat (3) @(posedge clk);
      wake <= 1'b0;
      seq_len(n);
      chk(n + 3, 2 * tab[i][1] + 4, 10);
      chk(mode, tab[i][3], 0);
      rd(4'h8, d, r);
      chk(d, {tab[i][2][16:0], tab[i][1][14:0]}, 0);
      t = 0;
      dprev = div_out;
      repeat (160) begin @(posedge clk); if (div_out !== dprev) t++; dprev = div_out; end
      chk(t, tab[i][0][7] ? 20 : 80, 2);
    end
    // Band code 001 belongs to no crystal kind, so no oscillator mode is chosen.
    wr(4'h0, 32'h02, r);
    chk(r, RESP_OKAY, 0);
    chk(mode, 0, 0);
    // A write without the low byte lane leaves the fuses alone.
    strb <= 4'he;
    wr(4'h0, 32'h08, r);
    strb <= 4'hf;
    chk(r, RESP_OKAY, 0);
    rd(4'h0, d, r);
    chk(d, 32'h02, 0);
    rd(4'hc, d, r);
    chk(r, RESP_SLVERR, 0);
    chk(d, 0, 0);
    wr(4'h4, 32'hff, r);
    chk(r, RESP_OKAY, 0);
    finish_test();
  end
endmodule // tb
